// ### core/lvds_tx_pkg.sv
package lvds_tx_pkg;

    // ========================================================
    // register map (byte addresses, one word each)
    // ========================================================
    localparam logic [11:0] CTRL_ADDR = 12'h000;
    localparam logic [11:0] STATUS_ADDR = 12'h004;
    localparam logic [11:0] COUNT_ADDR = 12'h008;

    // ========================================================
    // control field positions
    // ========================================================
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_FACTOR_LSB = 4;
    localparam int CTRL_RXCLK_LSB = 8;

    // ========================================================
    // status field positions
    // ========================================================
    localparam int STATUS_LOCKED_BIT = 0;
    localparam int STATUS_RX_STROBE_BIT = 1;
    localparam int STATUS_MODE_LSB = 4;

    // ========================================================
    // limits and reset values
    // ========================================================
    localparam int WORD_MAX = 10;
    localparam logic [3:0] FACTOR_MIN = 4'h3;
    localparam logic [3:0] FACTOR_MAX = 4'hA;
    localparam logic [3:0] FACTOR_RESET = 4'hA;
    localparam logic [31:0] PSLVERR_RDATA = 32'h0000_0000;

    // ========================================================
    // modes
    // ========================================================
    typedef enum logic [1:0] {
        MODE_SERIAL = 2'h0,
        MODE_SDR = 2'h1,
        MODE_DDR = 2'h2
    } tx_mode_t;

    typedef enum logic [1:0] {
        RXCLK_PLAIN = 2'h0,
        RXCLK_DYNAMIC_PHASE_ALIGN = 2'h1,
        RXCLK_SOFT_CLOCK_DATA_RECOVERY = 2'h2
    } rx_clock_mode_t;

    typedef struct packed {
        logic enable;
        tx_mode_t mode;
        logic [3:0] factor;
        rx_clock_mode_t rx_clock;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = '{
        enable: 1'b0,
        mode: MODE_SERIAL,
        factor: FACTOR_RESET,
        rx_clock: RXCLK_PLAIN
    };

endpackage

// ### core/lvds_shift_unit.sv
`timescale 1ns/1ps
module lvds_shift_unit #(
    parameter int W = 10
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // load side
    input wire logic i_load,
    input wire logic [W-1:0] i_word,
    input wire logic [3:0] i_factor,
    // serial side
    output logic o_bit
);

    logic [W-1:0] sh_q;
    logic [W-1:0] sh_d;
    logic [W-1:0] aligned;

    // move bit factor-1 to the top so the word leaves msb first
    assign aligned = i_word << (4'(W) - i_factor);

    assign sh_d = i_load ? aligned : {sh_q[W-2:0], 1'b0};

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sh_q <= '0;
        end else begin
            sh_q <= sh_d;
        end
    end

    assign o_bit = sh_q[W-1];

endmodule

// ### core/lvds_tx_serializer.sv
`timescale 1ns/1ps
// Operation
// - A parallel word of at most ten bits is taken per channel.
// - Words are captured in load registers, then shifted out on the fast clock.
// - Each word leaves most significant bit first.
// - Bypass takes one bit in SDR mode and two bits in DDR mode.
// - In the two phase recovery modes the receiver strobe goes unused and the receiver PLL is held in reset while unlocked.
// - The load strobe follows from a static factor of three through ten.
// - SDR bypass passes straight through; DDR bypass uses an output register.
module lvds_tx_serializer #(
    parameter int WORD_W = lvds_tx_pkg::WORD_MAX
) (
    // clock and reset (I_CLOCK is the fast serial clock)
    input wire logic I_CLOCK,
    input wire logic I_RST,
    // apb slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // parallel word from core
    input wire logic [WORD_W-1:0] I_WORD,
    input wire logic I_WORD_VALID,
    output logic O_WORD_READY,
    // pll
    input wire logic I_PLL_LOCKED,
    // channel outputs
    output logic O_TX_SERIAL,
    output logic [1:0] O_DDR_PAIR,
    output logic O_LOAD_STROBE,
    output logic O_RX_LOAD_STROBE,
    output logic O_RX_PLL_RESET
);

    // ========================================================
    // pll lock synchroniser
    // ========================================================
    logic lock_meta_q;
    logic lock_q;

    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            lock_meta_q <= 1'b0;
            lock_q <= 1'b0;
        end else begin
            lock_meta_q <= I_PLL_LOCKED;
            lock_q <= lock_meta_q;
        end
    end

    // ========================================================
    // apb registers
    // ========================================================
    lvds_tx_pkg::ctrl_t ctrl_q;
    lvds_tx_pkg::ctrl_t ctrl_d;
    logic [31:0] count_q;
    logic [31:0] prdata_q;
    logic [31:0] rdata_mux;
    logic [31:0] status_word;
    logic [31:0] ctrl_word;
    logic apb_access;
    logic apb_wr;
    logic apb_rd;
    logic hit_ctrl;
    logic hit_status;
    logic hit_count;
    logic unmapped;
    logic [3:0] wr_factor;
    logic factor_ok;
    lvds_tx_pkg::tx_mode_t wr_mode;
    logic mode_ok;

    assign apb_access = I_PSEL && I_PENABLE;
    assign apb_wr = apb_access && I_PWRITE;
    // read data is captured in the setup cycle so that it already stands
    // in the access cycle, where the zero-wait master takes it; a count
    // read therefore returns the value one cycle before the access edge
    assign apb_rd = I_PSEL && !I_PENABLE && !I_PWRITE;
    assign hit_ctrl = I_PADDR == lvds_tx_pkg::CTRL_ADDR;
    assign hit_status = I_PADDR == lvds_tx_pkg::STATUS_ADDR;
    assign hit_count = I_PADDR == lvds_tx_pkg::COUNT_ADDR;
    assign unmapped = !(hit_ctrl || hit_status || hit_count);

    assign wr_factor = I_PWDATA[lvds_tx_pkg::CTRL_FACTOR_LSB +: 4];
    assign factor_ok = wr_factor >= lvds_tx_pkg::FACTOR_MIN
        && wr_factor <= lvds_tx_pkg::FACTOR_MAX;
    assign wr_mode = lvds_tx_pkg::tx_mode_t'(
        I_PWDATA[lvds_tx_pkg::CTRL_MODE_LSB +: 2]);
    assign mode_ok = wr_mode != 2'h3;

    // factor and mode only change while the channel is stopped, so the
    // factor stays static for the whole time words are flowing
    always_comb begin
        ctrl_d = ctrl_q;
        if (apb_wr && hit_ctrl) begin
            ctrl_d.enable = I_PWDATA[lvds_tx_pkg::CTRL_ENABLE_BIT];
            ctrl_d.rx_clock = lvds_tx_pkg::rx_clock_mode_t'(
                I_PWDATA[lvds_tx_pkg::CTRL_RXCLK_LSB +: 2]);
            if (!ctrl_q.enable && factor_ok) begin
                ctrl_d.factor = wr_factor;
            end
            if (!ctrl_q.enable && mode_ok) begin
                ctrl_d.mode = wr_mode;
            end
        end
    end

    // bit 3 is spare and reads as zero
    assign ctrl_word = {22'h0, ctrl_q.rx_clock, ctrl_q.factor,
        1'b0, ctrl_q.mode, ctrl_q.enable};

    // ========================================================
    // load strobe generation
    // ========================================================
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic running;
    logic serial_mode;
    logic load;
    logic shift_bit;

    assign running = ctrl_q.enable && lock_q;
    assign serial_mode = ctrl_q.mode == lvds_tx_pkg::MODE_SERIAL;
    assign load = running && serial_mode && cnt_q == 4'h0;
    assign cnt_d = load ? ctrl_q.factor - 4'h1
        : (cnt_q == 4'h0 ? 4'h0 : cnt_q - 4'h1);

    // idle words shift out as zeros rather than stalling the line
    logic [WORD_W-1:0] load_word;
    assign load_word = I_WORD_VALID ? I_WORD : '0;

    lvds_shift_unit #(
        .W(WORD_W)
    ) u_shift (
        .i_clk(I_CLOCK),
        .i_rst(I_RST),
        .i_load(load),
        .i_word(load_word),
        .i_factor(ctrl_q.factor),
        .o_bit(shift_bit)
    );

    // ========================================================
    // bypass paths
    // ========================================================
    logic [1:0] ddr_q;
    logic sdr_mode;
    logic ddr_mode;
    logic bypass_take;

    assign sdr_mode = ctrl_q.mode == lvds_tx_pkg::MODE_SDR;
    assign ddr_mode = ctrl_q.mode == lvds_tx_pkg::MODE_DDR;
    assign bypass_take = running && !serial_mode && I_WORD_VALID;

    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            ddr_q <= 2'h0;
        end else if (running && ddr_mode) begin
            ddr_q <= I_WORD_VALID ? I_WORD[1:0] : 2'h0;
        end
    end

    // ========================================================
    // state registers
    // ========================================================
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            ctrl_q <= lvds_tx_pkg::CTRL_RESET;
            cnt_q <= 4'h0;
            count_q <= 32'h0000_0000;
            prdata_q <= 32'h0000_0000;
        end else begin
            ctrl_q <= ctrl_d;
            cnt_q <= running ? cnt_d : 4'h0;
            if (O_WORD_READY && I_WORD_VALID) begin
                count_q <= count_q + 32'h0000_0001;
            end
            if (apb_rd) begin
                prdata_q <= rdata_mux;
            end
        end
    end

    // ========================================================
    // receiver side hookup
    // ========================================================
    logic rx_recovery;
    assign rx_recovery = ctrl_q.rx_clock != lvds_tx_pkg::RXCLK_PLAIN;
    // in recovery modes the receiver gets no strobe: it ignores it anyway
    assign O_RX_LOAD_STROBE = rx_recovery ? 1'b0 : load;
    assign O_RX_PLL_RESET = rx_recovery ? !lock_q : 1'b0;

    assign status_word = {26'h0, ctrl_q.mode, 2'h0,
        O_RX_LOAD_STROBE, lock_q};
    assign rdata_mux = hit_ctrl ? ctrl_word
        : hit_status ? status_word
        : hit_count ? count_q
        : lvds_tx_pkg::PSLVERR_RDATA;

    // ========================================================
    // outputs
    // ========================================================
    assign O_PREADY = 1'b1;
    assign O_PSLVERR = apb_access && unmapped;
    assign O_PRDATA = prdata_q;
    assign O_LOAD_STROBE = load;
    assign O_WORD_READY = load || bypass_take;
    assign O_DDR_PAIR = ddr_q;
    assign O_TX_SERIAL = !running ? 1'b0
        : sdr_mode ? (I_WORD_VALID & I_WORD[0])
        : ddr_mode ? ddr_q[1]
        : shift_bit;

endmodule

// ### test/lvds_tx_serializer_properties.sv
`timescale 1ns/1ps
module tx_checker #(parameter int WORD_W = 10) (
    // clock, apb, word and pll inputs
    input wire logic I_CLOCK,
    input wire logic I_RST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic [11:0] I_PADDR,
    input wire logic [WORD_W-1:0] I_WORD,
    input wire logic I_PLL_LOCKED,
    // outputs watched
    input wire logic O_PREADY,
    input wire logic O_PSLVERR,
    input wire logic O_WORD_READY,
    input wire logic [1:0] O_DDR_PAIR,
    input wire logic O_LOAD_STROBE,
    input wire logic O_RX_LOAD_STROBE,
    input wire logic O_RX_PLL_RESET
);
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);
    wire acc = I_PSEL && I_PENABLE;
    a_strobe_gap: assert property (
        O_LOAD_STROBE |=> !O_LOAD_STROBE [*2]) else $error("strobe gap");
    a_rx_strobe: assert property (
        O_RX_LOAD_STROBE |-> O_LOAD_STROBE) else $error("rx strobe");
    a_rx_reset: assert property (
        O_RX_PLL_RESET |-> !O_RX_LOAD_STROBE) else $error("rx reset");
    a_lock_clear: assert property (
        I_PLL_LOCKED [*4] |-> !O_RX_PLL_RESET) else $error("reset held");
    a_no_lock: assert property (
        !I_PLL_LOCKED [*4] |-> !O_WORD_READY) else $error("load unlocked");
    a_ddr_pair: assert property (
        $changed(O_DDR_PAIR) && O_DDR_PAIR != 2'h0
        |-> O_DDR_PAIR == $past(I_WORD[1:0])) else $error("ddr pair");
    a_pready_high: assert property (acc |-> O_PREADY)
        else $error("pready low");
    a_err_unmapped: assert property (acc && I_PADDR > 12'h008 |-> O_PSLVERR)
        else $error("no slave error");
endmodule
bind lvds_tx_serializer tx_checker #(.WORD_W(WORD_W)) tx_checker_i (
    .I_CLOCK, .I_RST, .I_PSEL, .I_PENABLE, .I_PADDR, .I_WORD,
    .I_PLL_LOCKED, .O_PREADY, .O_PSLVERR, .O_WORD_READY, .O_DDR_PAIR,
    .O_LOAD_STROBE, .O_RX_LOAD_STROBE, .O_RX_PLL_RESET);

// ### test/core_fabric_model.sv
`timescale 1ns/1ps
module core_fabric_model (
    // clock and lock request
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_lock_on,
    // word handshake
    input wire logic i_ready,
    output logic [9:0] o_word = 10'h000,
    output logic o_valid = 1'b0,
    output logic o_locked = 1'b0
);
    integer seed = 39;
    // integer-mode pll: lock is a clean level
    always @(posedge i_clk) o_locked <= i_lock_on;
    // a fresh word after each one taken, now and then not valid
    always @(posedge i_clk) begin
        if (i_rst || i_ready) begin
            o_word <= 10'($random(seed));
            o_valid <= ($random(seed) % 5) != 0;
        end
    end
endmodule

// ### test/tb_lvds_tx_serializer.sv
`timescale 1ns/1ps
module tb_lvds_tx_serializer;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic lock_on = 1'b0, run = 1'b0, e;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prd, rd;
    logic [9:0] word;
    logic [1:0] ddr, prev;
    logic valid, ready, locked, tx, ld, rxld, rxrst, prdy, perr;
    logic [3:0] fac;
    logic [3:0] facs[3] = '{4'h3, 4'hA, 4'h7};
    logic q[$];
    int n_errors = 0, comparisons = 0, cyc = 0;
    int gap = 0;
    lvds_tx_serializer #(.WORD_W(10)) lvds_tx_serializer_i (
        .I_CLOCK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prd), .O_PREADY(prdy), .O_PSLVERR(perr),
        .I_WORD(word), .I_WORD_VALID(valid), .O_WORD_READY(ready),
        .I_PLL_LOCKED(locked), .O_TX_SERIAL(tx), .O_DDR_PAIR(ddr),
        .O_LOAD_STROBE(ld), .O_RX_LOAD_STROBE(rxld),
        .O_RX_PLL_RESET(rxrst)); // hookup optional, checked in the rx hookup test
    core_fabric_model core_fabric_model_i (.i_clk(clk), .i_rst(rst),
        .i_lock_on(lock_on), .i_ready(ready), .o_word(word),
        .o_valid(valid), .o_locked(locked));
    initial forever #4 clk = ~clk;
    // ========
    // tasks
    task automatic chk(input string n, input logic [31:0] x, g);
        comparisons++;
        if (g !== x) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (prdy !== 1'b1) @(posedge clk);
        e = perr;
        rd = prd;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic stop_test;
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            stop_test();
        end
    end
    // the queue holds each loaded word's bits in the order they must leave
    always @(posedge clk) begin
        if (run && q.size() > 0) chk("serial", q.pop_front(), tx);
        if (run && ready)
            for (int i = fac - 1; i >= 0; i--) q.push_back(valid & word[i]);
        if (!run) begin
            gap = 0;
        end else if (ld) begin
            if (gap > 0) chk("load gap", 32'(fac), gap);
            gap = 1;
        end else if (gap > 0) begin
            gap++;
        end
    end
    // ========
    // scenarios
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(1'b0, lvds_tx_pkg::CTRL_ADDR, 32'h0);
        chk("ctrl", 32'h0000_00A0, rd);
        bus(1'b0, 12'h00C, 32'h0);
        chk("pslverr", 32'h1, e);
        chk("unmapped", lvds_tx_pkg::PSLVERR_RDATA, rd);
        $display("reset test done");
        foreach (facs[i]) begin
            fac = facs[i];
            q.delete();
            run <= 1'b1;
            bus(1'b1, lvds_tx_pkg::CTRL_ADDR, {24'h0, fac, 4'h1});
            if (i == 0) begin
                repeat (8) @(posedge clk);
                chk("ready unlocked", 32'h0, ready);
                lock_on <= 1'b1;
            end
            repeat (30) @(posedge clk);
            bus(1'b1, lvds_tx_pkg::CTRL_ADDR, {24'h0, 4'h5, 4'h1});
            bus(1'b0, lvds_tx_pkg::CTRL_ADDR, 32'h0);
            chk("factor held", {24'h0, fac, 4'h1}, rd);
            repeat (30) @(posedge clk);
            run <= 1'b0;
            bus(1'b1, lvds_tx_pkg::CTRL_ADDR, 32'h0);
        end
        $display("serial test done");
        for (logic [1:0] m = 2'h1; m <= 2'h2; m++) begin
            bus(1'b1, lvds_tx_pkg::CTRL_ADDR, {24'h0, 4'hA, 1'b0, m, 1'b1});
            repeat (4) @(posedge clk);
            repeat (8) begin
                @(posedge clk);
                prev = valid ? word[1:0] : 2'h0;
                #1;
                if (m == 2'h1)
                    chk("sdr", {31'h0, word[0] & valid}, tx);
                else
                    chk("ddr", {30'h0, prev}, ddr);
            end
            bus(1'b1, lvds_tx_pkg::CTRL_ADDR, 32'h0);
        end
        $display("bypass test done");
        for (logic [1:0] r = 2'h0; r <= 2'h2; r++) begin
            bus(1'b1, lvds_tx_pkg::CTRL_ADDR, {22'h0, r, 8'h0});
            chk("rx reset locked", 32'h0, rxrst);
            lock_on <= 1'b0;
            repeat (6) @(posedge clk);
            chk("rx reset", {31'h0, r != 2'h0}, rxrst);
            lock_on <= 1'b1;
            repeat (6) @(posedge clk);
        end
        $display("rx hookup test done");
        stop_test();
    end
endmodule
